// >>> src/aesb_consts.vh
// Constants for the almost-empty flag status bus block.
`ifndef AESB_CONSTS_VH
`define AESB_CONSTS_VH
// Register byte offsets.
`define AESB_ADDR_CTRL 4'h0
`define AESB_ADDR_STATUS 4'h4
`define AESB_ADDR_MASK 4'h8
`define AESB_ADDR_STATE 4'hc
// Control register fields and reset value.
`define AESB_CTRL_BUS_EN 0
`define AESB_CTRL_RESET 1'h1
// Event bits in the status and mask registers.
`define AESB_EV_TOKEN 0
`define AESB_EV_SECTOR 1
`define AESB_EV_CLASH 2
`define AESB_EV_W 3
`define AESB_MASK_RESET 3'h0
// Read address field positions.
`define AESB_ADDR_SECTOR_BIT 0
`define AESB_ADDR_ID_HI 7
`define AESB_ADDR_ID_LO 5
// Polled hold window, sector-0 cycle included.
`define AESB_HOLD_LAST 2'h3
// Flag mode encodings.
`define AESB_MODE_DIRECT 1'b0
`define AESB_MODE_POLLED 1'b1
// Queues served by one sector.
`define AESB_SECTOR_QUEUES 5'h08
`endif

// >>> src/aesb_sector_mux.v
// Registered selection of one eight-queue sector of almost-empty flags.
`timescale 1ns/1ns
`include "aesb_consts.vh"
module aesb_sector_mux #(
    parameter NQ = 16
) (
    // Clock and reset.
    input wire i_clk,
    input wire i_rst_n,
    // Flags and selection.
    input wire [NQ-1:0] i_flags,
    input wire i_load,
    input wire i_sector,
    // Sector on the bus.
    output reg [7:0] o_bus
);
    // Low and high halves of the queue flags.
    wire [7:0] low_half;
    wire [7:0] high_half;

    assign low_half = i_flags[7:0];
    assign high_half = i_flags[NQ-1:8];

    // Load the chosen sector; bits of unset queues simply follow their flag.
    always @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_bus <= 8'h00;
        end else if (i_load) begin
            o_bus <= i_sector ? high_half : low_half;
        end
    end
endmodule

// >>> src/aesb_status_bus.v
// Almost-empty flag status bus with direct and polled sharing.
//
// Chosen here: the address-and-strobe port and the register addresses.
`timescale 1ns/1ns
`include "aesb_consts.vh"
module aesb_status_bus #(
    parameter NQ = 16
) (
    // Clock and asynchronous active-low master reset.
    input wire i_clk,
    input wire i_resetn,
    // Static straps and identity pins.
    input wire i_flag_mode_select,
    input wire i_master_select,
    input wire [2:0] i_device_identity,
    // Direct-mode selection pins.
    input wire [7:0] i_read_address_bus,
    input wire i_empty_status_strobe,
    // Token ring pin.
    input wire i_empty_token_in,
    // Queue state from the read port logic.
    input wire [NQ-1:0] i_queue_almost_empty,
    input wire [4:0] i_queue_count,
    input wire [3:0] i_read_queue,
    input wire i_read_queue_select,
    input wire i_output_valid,
    // Register port.
    input wire [3:0] i_reg_addr,
    input wire [31:0] i_reg_wdata,
    input wire i_reg_write,
    input wire i_reg_read,
    output reg [31:0] o_reg_rdata,
    // Discrete read port flags.
    output reg o_output_valid_flag,
    output reg o_almost_empty_flag,
    // Shared status bus and its low-active enable.
    output wire [7:0] o_almost_empty_status_bus,
    output reg o_status_bus_oe_n,
    // Polled-mode ring outputs.
    output reg o_empty_sector_sync,
    output reg o_empty_token_out,
    // Interrupt.
    output wire o_irq
);
    // Polled state machine codes.
    localparam ST_WAIT = 2'h0;
    localparam ST_HOLD = 2'h1;
    localparam ST_IDLE = 2'h2;

    // Reset release and pin synchronisers.
    reg [1:0] rst_sync_r;
    wire rst_n;
    reg [13:0] pin_meta_r;
    reg [13:0] pin_sync_r;
    wire mode_pin;
    wire master_pin;
    wire [2:0] id_pin;
    wire [7:0] addr_pin;
    wire strobe_pin;
    wire token_pin;

    // Straps and block state.
    reg started_r;
    reg mode_r;
    reg master_r;
    reg [2:0] id_r;
    reg [1:0] state_r;
    reg [1:0] state_nxt;
    reg [1:0] hold_cnt_r;
    reg [1:0] hold_cnt_nxt;
    reg sector_r;
    reg sector_nxt;
    reg load_nxt;
    reg selected_r;
    reg drive_r;
    reg drive_nxt;
    reg sync_nxt;
    reg token_out_nxt;
    reg token_prev_r;
    reg [1:0] sel_dly_r;
    wire token_edge;
    wire addr_match;
    wire few_queues;
    wire strobe_ok;

    // Software registers.
    reg ctrl_bus_en_r;
    reg [`AESB_EV_W-1:0] status_r;
    reg [`AESB_EV_W-1:0] mask_r;
    reg [`AESB_EV_W-1:0] events;
    reg [`AESB_EV_W-1:0] rd_clear;
    reg [31:0] rdata_nxt;

    // Two flops release the reset so all logic leaves reset on one edge.
    always @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            rst_sync_r <= 2'b00;
        end else begin
            rst_sync_r <= {rst_sync_r[0], 1'b1};
        end
    end
    assign rst_n = rst_sync_r[1];

    // Every strap, address and strobe pin passes two flops before any logic looks at it.
    // They have no reset, so straps held during reset are settled when caught.
    always @(posedge i_clk) begin
        pin_meta_r <= {i_flag_mode_select, i_master_select, i_device_identity,
                       i_read_address_bus, i_empty_status_strobe};
        pin_sync_r <= pin_meta_r;
    end
    assign mode_pin = pin_sync_r[13];
    assign master_pin = pin_sync_r[12];
    assign id_pin = pin_sync_r[11:9];
    assign addr_pin = pin_sync_r[8:1];
    assign strobe_pin = pin_sync_r[0];

    // The token pin has its own pair so its edge is seen cleanly.
    reg token_meta_r;
    reg token_sync_r;
    always @(posedge i_clk or negedge rst_n) begin
        if (!rst_n) begin
            token_meta_r <= 1'b0;
            token_sync_r <= 1'b0;
            token_prev_r <= 1'b0;
            sel_dly_r <= 2'b00;
        end else begin
            token_meta_r <= i_empty_token_in;
            token_sync_r <= token_meta_r;
            token_prev_r <= token_sync_r;
            sel_dly_r <= {sel_dly_r[0], i_read_queue_select};
        end
    end
    assign token_pin = token_sync_r;
    assign token_edge = token_pin & ~token_prev_r;

    // Straps are caught once, in the first cycle after the reset release.
    always @(posedge i_clk or negedge rst_n) begin
        if (!rst_n) begin
            started_r <= 1'b0;
            mode_r <= `AESB_MODE_DIRECT;
            master_r <= 1'b0;
            id_r <= 3'h0;
        end else if (!started_r) begin
            started_r <= 1'b1;
            mode_r <= mode_pin;
            master_r <= master_pin;
            id_r <= id_pin;
        end
    end

    assign addr_match = (addr_pin[`AESB_ADDR_ID_HI:`AESB_ADDR_ID_LO] == id_r);
    assign few_queues = (i_queue_count <= `AESB_SECTOR_QUEUES);
    assign strobe_ok = started_r & (mode_r == `AESB_MODE_DIRECT) & strobe_pin;

    // Next sector, bus ownership, sync and token for both sharing modes.
    always @* begin
        state_nxt = state_r;
        hold_cnt_nxt = hold_cnt_r;
        sector_nxt = sector_r;
        load_nxt = 1'b1;
        drive_nxt = drive_r;
        sync_nxt = 1'b0;
        token_out_nxt = 1'b0;
        if (!started_r) begin
            load_nxt = 1'b0;
            drive_nxt = 1'b0;
        end else if (mode_r == `AESB_MODE_DIRECT) begin
            if (strobe_ok) begin
                sector_nxt = addr_pin[`AESB_ADDR_SECTOR_BIT];
            end
            if (few_queues) begin
                sector_nxt = 1'b0;
            end
            drive_nxt = strobe_ok ? addr_match : selected_r;
        end else begin
            case (state_r)
                ST_IDLE: begin
                    if (master_r) begin
                        state_nxt = ST_HOLD;
                        hold_cnt_nxt = 2'h0;
                        sector_nxt = 1'b0;
                        drive_nxt = 1'b1;
                        sync_nxt = 1'b1;
                    end else begin
                        state_nxt = ST_WAIT;
                        drive_nxt = 1'b0;
                    end
                end
                ST_WAIT: begin
                    if (token_edge) begin
                        state_nxt = ST_HOLD;
                        hold_cnt_nxt = 2'h0;
                        sector_nxt = 1'b0;
                        drive_nxt = 1'b1;
                        sync_nxt = 1'b1;
                    end else begin
                        drive_nxt = 1'b0;
                    end
                end
                ST_HOLD: begin
                    if (hold_cnt_r == `AESB_HOLD_LAST) begin
                        state_nxt = ST_WAIT;
                        drive_nxt = 1'b0;
                    end else begin
                        hold_cnt_nxt = hold_cnt_r + 2'h1;
                        sector_nxt = ~sector_r;
                        drive_nxt = 1'b1;
                        if (hold_cnt_r == `AESB_HOLD_LAST - 2'h1) begin
                            token_out_nxt = 1'b1;
                        end
                    end
                end
                default: begin
                    state_nxt = ST_IDLE;
                    drive_nxt = 1'b0;
                end
            endcase
        end
    end

    // Bus control registers; sector load and ownership change on one edge.
    always @(posedge i_clk or negedge rst_n) begin
        if (!rst_n) begin
            state_r <= ST_IDLE;
            hold_cnt_r <= 2'h0;
            sector_r <= 1'b0;
            selected_r <= 1'b0;
            drive_r <= 1'b0;
            o_empty_sector_sync <= 1'b0;
            o_empty_token_out <= 1'b0;
        end else begin
            state_r <= state_nxt;
            hold_cnt_r <= hold_cnt_nxt;
            sector_r <= sector_nxt;
            drive_r <= drive_nxt;
            o_empty_sector_sync <= sync_nxt;
            o_empty_token_out <= token_out_nxt;
            if (!started_r) begin
                selected_r <= master_pin;
            end else if (strobe_ok) begin
                selected_r <= addr_match;
            end
        end
    end

    aesb_sector_mux #(
        .NQ(NQ)
    ) u_mux (
        .i_clk(i_clk),
        .i_rst_n(rst_n),
        .i_flags(i_queue_almost_empty),
        .i_load(load_nxt),
        .i_sector(sector_nxt),
        .o_bus(o_almost_empty_status_bus)
    );

    always @(posedge i_clk or negedge rst_n) begin
        if (!rst_n) begin
            o_status_bus_oe_n <= 1'b1;
        end else begin
            o_status_bus_oe_n <= ~(drive_nxt & ctrl_bus_en_r);
        end
    end

    always @(posedge i_clk or negedge rst_n) begin
        if (!rst_n) begin
            o_output_valid_flag <= 1'b0;
            o_almost_empty_flag <= 1'b0;
        end else begin
            o_output_valid_flag <= i_output_valid;
            o_almost_empty_flag <= i_queue_almost_empty[i_read_queue];
        end
    end

    // Events that set sticky status bits.
    always @* begin
        events = {`AESB_EV_W{1'b0}};
        events[`AESB_EV_TOKEN] = token_out_nxt;
        events[`AESB_EV_SECTOR] = strobe_ok & addr_match;
        // flag a controller clash
        // The selection is delayed to line up with the synchronised strobe.
        events[`AESB_EV_CLASH] = strobe_ok & sel_dly_r[1];
    end

    // A status read clears what it returned; a new event still wins.
    always @* begin
        rd_clear = {`AESB_EV_W{1'b0}};
        if (i_reg_read && i_reg_addr == `AESB_ADDR_STATUS) begin
            rd_clear = status_r;
        end
    end

    // Software-visible registers.
    always @(posedge i_clk or negedge rst_n) begin
        if (!rst_n) begin
            ctrl_bus_en_r <= `AESB_CTRL_RESET;
            mask_r <= `AESB_MASK_RESET;
            status_r <= {`AESB_EV_W{1'b0}};
        end else begin
            status_r <= (status_r & ~rd_clear) | events;
            if (i_reg_write && i_reg_addr == `AESB_ADDR_CTRL) begin
                ctrl_bus_en_r <= i_reg_wdata[`AESB_CTRL_BUS_EN];
            end
            if (i_reg_write && i_reg_addr == `AESB_ADDR_MASK) begin
                mask_r <= i_reg_wdata[`AESB_EV_W-1:0];
            end
        end
    end

    assign o_irq = |(status_r & mask_r);

    // Read mux; unmapped offsets read zero.
    always @* begin
        rdata_nxt = 32'h00000000;
        case (i_reg_addr)
            `AESB_ADDR_CTRL: rdata_nxt[0] = ctrl_bus_en_r;
            `AESB_ADDR_STATUS: rdata_nxt[`AESB_EV_W-1:0] = status_r;
            `AESB_ADDR_MASK: rdata_nxt[`AESB_EV_W-1:0] = mask_r;
            `AESB_ADDR_STATE: rdata_nxt[9:0] = {id_r, state_r, drive_r, sector_r,
                                                 selected_r, master_r, mode_r};
            default: rdata_nxt = 32'h00000000;
        endcase
    end

    // Read data stand in the cycle after the strobe only.
    always @(posedge i_clk or negedge rst_n) begin
        if (!rst_n) begin
            o_reg_rdata <= 32'h00000000;
        end else if (i_reg_read) begin
            o_reg_rdata <= rdata_nxt;
        end else begin
            o_reg_rdata <= 32'h00000000;
        end
    end
endmodule

// >>> bench/aesb_status_bus_properties.sv
// Port-level checker of the almost-empty status bus block.
`timescale 1ns/1ns
module aesb_status_bus_chk #(
    parameter NQ = 16
) (
    input wire i_clk,
    input wire i_resetn,
    input wire i_flag_mode_select,
    input wire [2:0] i_device_identity,
    input wire [7:0] i_read_address_bus,
    input wire i_empty_status_strobe,
    input wire [NQ-1:0] i_queue_almost_empty,
    input wire [4:0] i_queue_count,
    input wire [3:0] i_read_queue,
    input wire i_output_valid,
    input wire i_reg_read,
    input wire [31:0] o_reg_rdata,
    input wire o_output_valid_flag,
    input wire o_almost_empty_flag,
    input wire [7:0] o_almost_empty_status_bus,
    input wire o_status_bus_oe_n,
    input wire o_empty_sector_sync,
    input wire o_empty_token_out,
    input wire o_irq
);
    reg [2:0] up_cnt_r;
    // Count edges since the reset pin rose; the block's own reset lags it.
    always @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            up_cnt_r <= 3'h0;
        end else if (up_cnt_r != 3'h4) begin
            up_cnt_r <= up_cnt_r + 3'h1;
        end
    end
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_resetn || up_cnt_r != 3'h4);
    chk_read_flags: assert property (
        o_output_valid_flag == $past(i_output_valid) &&
        o_almost_empty_flag == $past(i_queue_almost_empty[i_read_queue]))
        else $error("read port flags wrong");
    chk_dir_release: assert property (
        !i_flag_mode_select && $past(i_empty_status_strobe, 2) &&
        $past(i_read_address_bus[7:5], 2) != i_device_identity |=> o_status_bus_oe_n)
        else $error("bus not released on foreign strobe");
    chk_dir_sector: assert property (
        !i_flag_mode_select && $past(i_empty_status_strobe, 2) &&
        $past(i_read_address_bus[7:5], 2) == i_device_identity |=>
        !o_status_bus_oe_n && o_almost_empty_status_bus ==
        (($past(i_read_address_bus[0], 3) && i_queue_count > 5'h08) ?
        $past(i_queue_almost_empty[15:8]) : $past(i_queue_almost_empty[7:0])))
        else $error("selected sector wrong");
    chk_hold_four: assert property (
        o_empty_sector_sync |-> (!o_status_bus_oe_n)[*4] ##1 o_status_bus_oe_n)
        else $error("polled hold window wrong");
    chk_token_time: assert property (
        o_empty_sector_sync |-> ##3 o_empty_token_out)
        else $error("token not passed on time");
    chk_sector_cycle: assert property (
        o_empty_sector_sync |->
        o_almost_empty_status_bus == $past(i_queue_almost_empty[7:0]) ##1
        (!o_empty_sector_sync &&
        o_almost_empty_status_bus == $past(i_queue_almost_empty[15:8])) ##1
        o_almost_empty_status_bus == $past(i_queue_almost_empty[7:0]) ##1
        o_almost_empty_status_bus == $past(i_queue_almost_empty[15:8]))
        else $error("polled sector order wrong");
    chk_token_release: assert property (
        o_empty_token_out |=> o_status_bus_oe_n && !o_empty_token_out)
        else $error("bus held after token");
    // Read data stand only in the cycle after a read.
    chk_rdata_idle: assert property (!$past(i_reg_read) |-> o_reg_rdata == 32'h0)
        else $error("read data outside read cycle");
    cover property (o_empty_sector_sync);
    cover property (o_empty_token_out);
    cover property (o_irq);
endmodule
bind aesb_status_bus aesb_status_bus_chk #(.NQ(NQ)) i_aesb_status_bus_chk (
    .i_clk(i_clk), .i_resetn(i_resetn), .i_flag_mode_select(i_flag_mode_select),
    .i_device_identity(i_device_identity), .i_read_address_bus(i_read_address_bus),
    .i_empty_status_strobe(i_empty_status_strobe),
    .i_queue_almost_empty(i_queue_almost_empty), .i_queue_count(i_queue_count),
    .i_read_queue(i_read_queue), .i_output_valid(i_output_valid),
    .i_reg_read(i_reg_read), .o_reg_rdata(o_reg_rdata),
    .o_output_valid_flag(o_output_valid_flag), .o_almost_empty_flag(o_almost_empty_flag),
    .o_almost_empty_status_bus(o_almost_empty_status_bus),
    .o_status_bus_oe_n(o_status_bus_oe_n), .o_empty_sector_sync(o_empty_sector_sync),
    .o_empty_token_out(o_empty_token_out), .o_irq(o_irq));

// >>> bench/aesb_ring_peer.sv
// Model of the rest of the token ring that returns the token after a delay.
`timescale 1ns/1ns
module aesb_ring_peer #(
    parameter int DELAY = 6
) (
    // Clock and reset.
    input wire logic i_clk,
    input wire logic i_resetn,
    // Token from the device and a first-token kick.
    input wire logic i_token,
    input wire logic i_start,
    // Token back to the device.
    output logic o_token
);
    int cnt;
    always @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            cnt <= 0;
            o_token <= 1'b0;
        end else begin
            o_token <= (cnt == 1);
            if (i_token || i_start) begin
                cnt <= DELAY;
            end else if (cnt > 0) begin
                cnt <= cnt - 1;
            end
        end
    end
endmodule

// >>> bench/aesb_status_bus_tb.sv
// Self-checking bench of the almost-empty status bus in direct and polled modes.
`timescale 1ns/1ns
module aesb_status_bus_tb;
    localparam logic [15:0] FL = 16'h3ca5;
    logic i_clk = 1'b0;
    logic i_resetn = 1'b0;
    logic fm = 1'b0, ms = 1'b1, stb = 1'b0, start = 1'b0, sel = 1'b0, ov = 1'b0;
    logic wr = 1'b0, rd = 1'b0, tok_in, tok_out, sync, oe_n, irq, ov_f, ae_f;
    logic [7:0] addr = 8'h00, bus;
    logic [4:0] qcnt = 5'h10;
    logic [3:0] rq = 4'h0, ra = 4'h0;
    logic [31:0] wd = 32'h0, rdata;
    int n_fail = 0, n_checks = 0;
    aesb_status_bus #(.NQ(16)) i_aesb_status_bus (
        .i_clk(i_clk), .i_resetn(i_resetn), .i_flag_mode_select(fm),
        .i_master_select(ms), .i_device_identity(3'h2), .i_read_address_bus(addr),
        .i_empty_status_strobe(stb), .i_empty_token_in(tok_in),
        .i_queue_almost_empty(FL), .i_queue_count(qcnt), .i_read_queue(rq),
        .i_read_queue_select(sel), .i_output_valid(ov), .i_reg_addr(ra),
        .i_reg_wdata(wd), .i_reg_write(wr), .i_reg_read(rd), .o_reg_rdata(rdata),
        .o_output_valid_flag(ov_f), .o_almost_empty_flag(ae_f),
        .o_almost_empty_status_bus(bus), .o_status_bus_oe_n(oe_n),
        .o_empty_sector_sync(sync), .o_empty_token_out(tok_out), .o_irq(irq));
    aesb_ring_peer #(.DELAY(6)) i_aesb_ring_peer (.i_clk(i_clk), .i_resetn(i_resetn),
        .i_token(tok_out), .i_start(start), .o_token(tok_in));
    // Clock of 40 ns period.
    initial begin
        forever #20 i_clk = ~i_clk;
    end
    task automatic cyc(input int n);
        repeat (n) @(posedge i_clk);
    endtask
    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        n_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("Error %s expected %h seen %h", name, exp, got);
        end
    endtask
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    task automatic do_reset(input logic mode, input logic master_select);
        @(posedge i_clk);
        i_resetn <= 1'b0;
        ov <= 1'b0;
        fm <= mode;
        ms <= master_select;
        cyc(10);
        i_resetn <= 1'b1;
        cyc(4);
    endtask
    task automatic reg_wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge i_clk);
        ra <= a;
        wd <= d;
        wr <= 1'b1;
        @(posedge i_clk);
        wr <= 1'b0;
    endtask
    task automatic reg_rd(input logic [3:0] a, input logic [31:0] exp);
        @(posedge i_clk);
        ra <= a;
        rd <= 1'b1;
        @(posedge i_clk);
        rd <= 1'b0;
        @(negedge i_clk);
        chk("reg read", exp, rdata);
    endtask
    task automatic strobe(input logic [7:0] a);
        @(posedge i_clk);
        stb <= 1'b1;
        addr <= a;
        @(posedge i_clk);
        stb <= 1'b0;
    endtask
    task automatic wait_sync(input int bound);
        int k;
        k = 0;
        @(negedge i_clk);
        while (sync !== 1'b1) begin
            k++;
            if (k > bound) begin
                n_fail++;
                $display("Error sector sync expected 1 seen %b", sync);
                tally_and_finish();
            end
            @(negedge i_clk);
        end
    endtask
    task automatic polled_round();
        for (int i = 0; i < 4; i++) begin
            chk("polled bus", i[0] ? FL[15:8] : FL[7:0], bus);
            chk("polled drive", 1'b0, oe_n);
            chk("sector sync", i == 0, sync);
            chk("token out", i == 3, tok_out);
            @(negedge i_clk);
        end
        chk("polled release", 1'b1, oe_n);
        $display("polled round done");
    endtask
    // Direct mode, then polled master, then polled follower.
    initial begin
        do_reset(1'b0, 1'b1);
        @(negedge i_clk);
        chk("default drive", 1'b0, oe_n);
        chk("default sector", FL[7:0], bus);
        reg_rd(4'h0, 32'h1);
        reg_rd(4'h8, 32'h0);
        reg_rd(4'h2, 32'h0);
        reg_rd(4'h4, 32'h0);
        for (int s = 0; s < 2; s++) begin
            strobe(8'h40 | s[7:0]);
            cyc(2);
            @(negedge i_clk);
            chk("direct sector", s ? FL[15:8] : FL[7:0], bus);
        end
        @(posedge i_clk);
        stb <= 1'b1;
        addr <= 8'h41;
        @(posedge i_clk);
        addr <= 8'h40;
        @(posedge i_clk);
        stb <= 1'b0;
        @(posedge i_clk);
        @(negedge i_clk);
        chk("back to back first", FL[15:8], bus);
        @(negedge i_clk);
        chk("back to back second", FL[7:0], bus);
        strobe(8'h61);
        cyc(2);
        @(negedge i_clk);
        chk("foreign id release", 1'b1, oe_n);
        strobe(8'h40);
        reg_wr(4'h8, 32'h2);
        @(negedge i_clk);
        chk("irq raised", 1'b1, irq);
        reg_rd(4'h4, 32'h2);
        chk("irq cleared", 1'b0, irq);
        @(posedge i_clk);
        stb <= 1'b1;
        sel <= 1'b1;
        addr <= 8'h41;
        cyc(3);
        stb <= 1'b0;
        sel <= 1'b0;
        cyc(3);
        reg_rd(4'h4, 32'h6);
        reg_wr(4'h0, 32'h0);
        @(posedge i_clk);
        @(negedge i_clk);
        chk("bus disabled", 1'b1, oe_n);
        reg_wr(4'h0, 32'h1);
        qcnt <= 5'h08;
        strobe(8'h41);
        cyc(2);
        @(negedge i_clk);
        chk("eight queue sector", FL[7:0], bus);
        @(posedge i_clk);
        rq <= 4'h5;
        ov <= 1'b1;
        @(posedge i_clk);
        @(negedge i_clk);
        chk("almost empty flag", FL[5], ae_f);
        chk("output valid flag", 1'b1, ov_f);
        $display("direct mode test done");
        do_reset(1'b1, 1'b1);
        wait_sync(10);
        polled_round();
        wait_sync(30);
        polled_round();
        reg_rd(4'h4, 32'h1);
        $display("polled master test done");
        do_reset(1'b1, 1'b0);
        for (int i = 0; i < 20; i++) begin
            @(negedge i_clk);
            chk("follower released", 1'b1, oe_n);
        end
        @(posedge i_clk);
        start <= 1'b1;
        @(posedge i_clk);
        start <= 1'b0;
        wait_sync(20);
        polled_round();
        $display("polled follower test done");
        tally_and_finish();
    end
endmodule
